/* File: design/tpwm_top.sv */
// Timer with six PWM channels, overflow counter, status flags and converter trigger.
// Assumes control inputs are one-cycle pulses from register logic on sys_clk_i.
`timescale 1ns/1ps
module tpwm_top #(
	parameter int INST_ID = tpwm_pkg::INST_ID_DEF,
	parameter int TICK_DIV = tpwm_pkg::TICK_DIV_DEF
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic counter_clear_request_i,
	input wire logic counter_go_i,
	input wire logic [tpwm_pkg::CNT_W-1:0] counter_top_value_i,
	input wire logic [1:0] snapshot_update_mode_i,
	input wire logic [tpwm_pkg::NCH-1:0][2:0] channel_function_select_i,
	input wire logic [tpwm_pkg::NCH-1:0] output_polarity_i,
	input wire logic [tpwm_pkg::NCH-1:0][tpwm_pkg::MATCH_W-1:0] match_value_first_i,
	input wire logic [tpwm_pkg::NCH-1:0][tpwm_pkg::MATCH_W-1:0] match_value_second_i,
	input wire logic [tpwm_pkg::NCH-1:0] channel_restart_i,
	input wire logic [tpwm_pkg::NCH-1:0] match_update_request_i,
	input wire logic [tpwm_pkg::SEL_W-1:0] trigger_source_channel_i,
	input wire logic trigger_enable_i,
	input wire logic [tpwm_pkg::DLY_W-1:0] trigger_delay_i,
	input wire logic [tpwm_pkg::STS_W-1:0] status_clear_i,
	input wire logic [tpwm_pkg::STS_W-1:0] interrupt_mask_reg_i,
	output logic reset_released_flag_o,
	output logic counter_clear_done_o,
	output logic counter_running_o,
	output logic [tpwm_pkg::CNT_W-1:0] counter_snapshot_o,
	output logic [tpwm_pkg::NCH-1:0] pwm_o,
	output logic [tpwm_pkg::NCH-1:0] channel_status_o,
	output logic [tpwm_pkg::NCH-1:0] channel_error_flag_o,
	output logic overflow_status_o,
	output logic [tpwm_pkg::STS_W-1:0] interrupt_status_o,
	output logic irq_o,
	output logic adc_start_o,
	output logic dac_start_o
);
	import tpwm_pkg::*;

	localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);
	localparam logic HAS_ADC = (INST_ID == 0) || (INST_ID == 1);
	localparam logic HAS_DAC = (INST_ID == 2) || (INST_ID == 3);

	logic rst_s1_reg, rst_s2_reg, rst_n;
	logic released_reg;
	logic [15:0] div_reg;
	logic tick, step;
	logic [CNT_W-1:0] cnt_reg, top_act_reg, snap_reg;
	logic [1:0] snap_div_reg;
	logic clr_pend_reg, go_pend_reg, clr_done_reg, running_reg;
	logic wrap, clr_now, ovf_evt;
	logic [STS_W-1:0] sts_reg, sts_evt;
	logic [NCH-1:0] pe_w, pwm_mode_w, err_evt;
	logic [DLY_W+1:0] trig_cnt_reg;
	logic trig_arm_reg, trig_fire_reg;
	logic src_pe, src_pwm, trig_ok;

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// Flag rises one edge after internal reset is released
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			released_reg <= 1'b0;
		end else begin
			released_reg <= 1'b1;
		end
	end

	// Counter clock tick divider
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 16'h0000;
		end else if (div_reg >= DIV_LAST) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end
	assign tick = (div_reg >= DIV_LAST);
	assign step = tick && running_reg;

	// Counter decode
	assign clr_now = tick && clr_pend_reg;
	assign wrap = step && (cnt_reg == top_act_reg);
	assign ovf_evt = wrap && !clr_now;

	// Counter, top value and clear/go handshake
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= COUNTER_CLEAR_REQUEST_VAL;
			top_act_reg <= TOP_RESET_VAL;
			clr_pend_reg <= 1'b0;
			go_pend_reg <= 1'b0;
			clr_done_reg <= 1'b0;
			running_reg <= 1'b0;
		end else begin
			clr_pend_reg <= counter_clear_request_i || (clr_pend_reg && !tick);
			go_pend_reg <= counter_go_i || (go_pend_reg && !tick);
			if (counter_clear_request_i) begin
				clr_done_reg <= 1'b0;
			end else if (clr_now) begin
				clr_done_reg <= 1'b1;
			end
			if (tick && go_pend_reg) begin
				running_reg <= 1'b1;
			end
			if (clr_now) begin
				cnt_reg <= COUNTER_CLEAR_REQUEST_VAL;
				top_act_reg <= counter_top_value_i;
			end else if (wrap) begin
				cnt_reg <= COUNTER_CLEAR_REQUEST_VAL;
				top_act_reg <= counter_top_value_i;
			end else if (step) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	// Snapshot of the live count
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			snap_reg <= COUNTER_CLEAR_REQUEST_VAL;
			snap_div_reg <= 2'h0;
		end else if (tick) begin
			snap_div_reg <= snap_div_reg + 2'h1;
			if ((snapshot_update_mode_i == SNAP_FAST) ||
				((snapshot_update_mode_i == SNAP_NORMAL) && (snap_div_reg == SNAP_NORMAL_LAST))) begin
				snap_reg <= cnt_reg;
			end
		end
	end

	// Per-channel PWM generators
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		tpwm_ch_state_e st_reg, st_next;
		logic [MATCH_W:0] rem_reg, rem_next;
		logic [MATCH_W-1:0] m0_reg, m1_reg, sh0_reg, sh1_reg, m0_next, m1_next, n0, n1;
		logic out_reg, out_next, pend_reg, pend_next, rst_pend_reg, pe, ent, per;
		logic is_pwm, center, output_polarity;

		assign center = (channel_function_select_i[c] == FUNC_PWM_CENTER);
		assign is_pwm = center || (channel_function_select_i[c] == FUNC_PWM_EDGE);
		assign output_polarity = output_polarity_i[c];
		assign n0 = pend_reg ? sh0_reg : m0_reg;
		assign n1 = pend_reg ? sh1_reg : m1_reg;

		// Waveform sequencer
		always_comb begin
			st_next = st_reg;
			rem_next = rem_reg;
			out_next = out_reg;
			m0_next = m0_reg;
			m1_next = m1_reg;
			pend_next = pend_reg;
			pe = 1'b0;
			ent = 1'b0;
			per = 1'b0;
			if (!is_pwm) begin
				st_next = CH_IDLE;
				out_next = output_polarity;
			end else if (tick && rst_pend_reg) begin
				out_next = output_polarity;
				m0_next = match_value_first_i[c];
				m1_next = match_value_second_i[c];
				pend_next = 1'b0;
				if ((m0_next == '0) && (m1_next == '0)) begin
					st_next = CH_PAUSE;
				end else begin
					st_next = CH_LEAD;
					rem_next = center ? {1'b0, m1_next} : (MATCH_W+1)'(1);
				end
			end else if (step) begin
				case (st_reg)
					CH_LEAD: begin
						if (rem_reg <= (MATCH_W+1)'(1)) begin
							ent = 1'b1;
						end else begin
							rem_next = rem_reg - 1'b1;
						end
					end
					CH_HIGH: begin
						if (rem_reg <= (MATCH_W+1)'(1)) begin
							out_next = output_polarity;
							if (m1_reg != '0) begin
								st_next = CH_LOW;
								rem_next = {1'b0, m1_reg};
							end else begin
								per = 1'b1;
							end
						end else begin
							rem_next = rem_reg - 1'b1;
						end
					end
					CH_LOW: begin
						if (rem_reg <= (MATCH_W+1)'(1)) begin
							per = 1'b1;
						end else begin
							rem_next = rem_reg - 1'b1;
						end
					end
					CH_PAUSE: begin
						if (pend_reg) begin
							m0_next = sh0_reg;
							m1_next = sh1_reg;
							pend_next = 1'b0;
							if ((sh0_reg != '0) || (sh1_reg != '0)) begin
								out_next = output_polarity;
								st_next = CH_LEAD;
								rem_next = center ? {1'b0, sh1_reg} : (MATCH_W+1)'(1);
							end
						end
					end
					CH_IDLE: begin
						st_next = CH_IDLE;
					end
					default: begin
						st_next = CH_IDLE;
					end
				endcase
				if (per) begin
					pe = 1'b1;
					m0_next = n0;
					m1_next = n1;
					pend_next = 1'b0;
					if ((n0 == '0) && (n1 == '0)) begin
						st_next = CH_PAUSE;
					end else if (center && (n1 != '0)) begin
						st_next = CH_LEAD;
						rem_next = {1'b0, n1};
					end else begin
						ent = 1'b1;
					end
				end
				if (ent) begin
					if (m0_next != '0) begin
						out_next = !output_polarity;
						st_next = CH_HIGH;
						rem_next = center ? {m0_next, 1'b0} : {1'b0, m0_next};
					end else begin
						out_next = output_polarity;
						st_next = CH_LOW;
						rem_next = {1'b0, m1_next};
					end
				end
			end
		end

		// Channel state and request latches
		always_ff @(posedge sys_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				st_reg <= CH_IDLE;
				rem_reg <= '0;
				out_reg <= 1'b0;
				m0_reg <= MATCH_RESET_VAL;
				m1_reg <= MATCH_RESET_VAL;
				sh0_reg <= MATCH_RESET_VAL;
				sh1_reg <= MATCH_RESET_VAL;
				pend_reg <= 1'b0;
				rst_pend_reg <= 1'b0;
			end else begin
				st_reg <= st_next;
				rem_reg <= rem_next;
				out_reg <= out_next;
				m0_reg <= m0_next;
				m1_reg <= m1_next;
				pend_reg <= pend_next || match_update_request_i[c];
				rst_pend_reg <= channel_restart_i[c] || (rst_pend_reg && !tick);
				if (match_update_request_i[c]) begin
					sh0_reg <= match_value_first_i[c];
					sh1_reg <= match_value_second_i[c];
				end
			end
		end

		assign pe_w[c] = pe;
		assign pwm_mode_w[c] = is_pwm;
		assign err_evt[c] = match_update_request_i[c] && pend_next;
		assign pwm_o[c] = out_reg;
	end

	// Status events and write-one-to-clear, set wins
	assign sts_evt = {ovf_evt, err_evt, pe_w};
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sts_reg <= '0;
		end else begin
			sts_reg <= (sts_reg & ~status_clear_i) | sts_evt;
		end
	end

	// Trigger source selection
	assign trig_ok = trigger_source_channel_i < SEL_W'(NCH);
	assign src_pe = trig_ok && pe_w[trigger_source_channel_i];
	assign src_pwm = trig_ok && pwm_mode_w[trigger_source_channel_i];

	// Converter trigger delay, four ticks per unit
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			trig_cnt_reg <= '0;
			trig_arm_reg <= 1'b0;
			trig_fire_reg <= 1'b0;
		end else begin
			trig_fire_reg <= 1'b0;
			if (!(trigger_enable_i && src_pwm)) begin
				trig_arm_reg <= 1'b0;
			end else if (src_pe) begin
				if (trigger_delay_i == '0) begin
					trig_fire_reg <= 1'b1;
					trig_arm_reg <= 1'b0;
				end else begin
					trig_arm_reg <= 1'b1;
					trig_cnt_reg <= {2'b00, trigger_delay_i} << DLY_UNIT_SHIFT;
				end
			end else if (trig_arm_reg && step) begin
				if (trig_cnt_reg <= (DLY_W+2)'(1)) begin
					trig_fire_reg <= 1'b1;
					trig_arm_reg <= 1'b0;
				end else begin
					trig_cnt_reg <= trig_cnt_reg - 1'b1;
				end
			end
		end
	end

	// Outputs
	assign adc_start_o = HAS_ADC && trig_fire_reg;
	assign dac_start_o = HAS_DAC && trig_fire_reg;
	assign reset_released_flag_o = released_reg;
	assign counter_clear_done_o = clr_done_reg;
	assign counter_running_o = running_reg;
	assign counter_snapshot_o = snap_reg;
	assign channel_status_o = sts_reg[STS_CH_LSB +: NCH];
	assign channel_error_flag_o = sts_reg[STS_ERR_LSB +: NCH];
	assign overflow_status_o = sts_reg[STS_OVF_BIT];
	assign interrupt_status_o = sts_reg & ~interrupt_mask_reg_i;
	assign irq_o = |interrupt_status_o;
endmodule

/* File: common/tpwm_pkg.sv */
// Constants, field positions and state type for the timer PWM channel block.
// Assumes one system clock; the counter tick is an enable pulse made inside the block.
// Notes on behaviour
// - Function select 6 gives edge-aligned PWM.
// - Edge sequence: polarity, invert, match waits repeat.
// - First match zero 0%, second zero 100%.
// - Both matches zero pause, hold output, no events.
// - Function select 7 gives center-aligned PWM.
// - Center sequence: second, twice first, second.
// - ADC start on instances 0-1, DAC 2-3.
// - Trigger source picked from six channels.
// - Trigger only in PWM mode with enable set.
// - Trigger delayed from period end, four-tick units.
// - Reset-released flag set after reset completes.
// - Counter clear sets clear-done flag when finished.
// - Counter go sets counter-running flag.
// - Channel restart bit enables and restarts channel.
// - New top value waits overflow or clear.
// - Match update; error flag on overlapping request.
// - Write-one-clear status, masked view, interrupt line.
// - Count zero to top, wrap, set overflow.
package tpwm_pkg;
	localparam int NCH = 6;
	localparam int CNT_W = 16;
	localparam int MATCH_W = 16;
	localparam int DLY_W = 16;
	localparam int SEL_W = 3;
	localparam int INST_ID_DEF = 0;
	localparam int TICK_DIV_DEF = 1;
	localparam logic [2:0] FUNC_PWM_EDGE = 3'h6;
	localparam logic [2:0] FUNC_PWM_CENTER = 3'h7;
	localparam logic [1:0] DLY_UNIT_SHIFT = 2'h2;
	localparam logic [1:0] SNAP_NORMAL = 2'h0;
	localparam logic [1:0] SNAP_FAST = 2'h1;
	localparam logic [1:0] SNAP_OFF = 2'h3;
	localparam logic [1:0] SNAP_NORMAL_LAST = 2'h3;
	localparam int REQ_SPACING_TICKS = 5;
	localparam int STS_W = 2 * NCH + 1;
	localparam int STS_CH_LSB = 0;
	localparam int STS_ERR_LSB = NCH;
	localparam int STS_OVF_BIT = 2 * NCH;
	localparam logic [CNT_W-1:0] COUNTER_CLEAR_REQUEST_VAL = 16'h0000;
	localparam logic [CNT_W-1:0] TOP_RESET_VAL = 16'hFFFF;
	localparam logic [MATCH_W-1:0] MATCH_RESET_VAL = 16'h0000;
	typedef enum logic [2:0] {CH_IDLE, CH_LEAD, CH_HIGH, CH_LOW, CH_PAUSE} tpwm_ch_state_e;
endpackage

/* File: testbench/tpwm_asserts.sv */
// Port checker for the timer PWM block.
// Assumes one clock domain and bind onto every tpwm_top instance.
`timescale 1ns/1ps
module tpwm_asserts #(
	parameter int INST_ID = 0,
	parameter int TICK_DIV = 1
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic counter_clear_request_i,
	input wire logic counter_go_i,
	input wire logic trigger_enable_i,
	input wire logic [tpwm_pkg::STS_W-1:0] status_clear_i,
	input wire logic [tpwm_pkg::STS_W-1:0] interrupt_mask_reg_i,
	input wire logic reset_released_flag_o,
	input wire logic counter_clear_done_o,
	input wire logic counter_running_o,
	input wire logic [tpwm_pkg::NCH-1:0] channel_status_o,
	input wire logic [tpwm_pkg::NCH-1:0] channel_error_flag_o,
	input wire logic overflow_status_o,
	input wire logic [tpwm_pkg::STS_W-1:0] interrupt_status_o,
	input wire logic irq_o,
	input wire logic adc_start_o,
	input wire logic dac_start_o
);
	import tpwm_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Raw status vector in interrupt bit order
	wire [STS_W-1:0] sts_v = {overflow_status_o, channel_error_flag_o, channel_status_o};
	// Status, mask and interrupt line
	a_irq_any: assert property (irq_o == |interrupt_status_o) else $error("irq wrong");
	a_int_masked: assert property (interrupt_status_o == (sts_v & ~interrupt_mask_reg_i))
		else $error("masked view wrong");
	a_sts_sticky: assert property (channel_status_o[0] && !status_clear_i[0] |=>
		channel_status_o[0]) else $error("status lost");
	// Converter starts exist on their instances only; the ADC start stays off once the trigger has been disabled for three cycles
	a_adc_absent: assert property (INST_ID > 1 |-> !adc_start_o) else $error("adc");
	a_dac_absent: assert property (INST_ID < 2 || INST_ID > 3 |-> !dac_start_o)
		else $error("dac");
	a_trig_gated: assert property (!trigger_enable_i [*3] |-> !adc_start_o)
		else $error("trigger while disabled");
	// Start-up handshakes
	a_clr_drop: assert property (counter_clear_request_i |=> !counter_clear_done_o)
		else $error("clear done stayed");
	a_clr_back: assert property (counter_clear_request_i |-> ##[1:40] counter_clear_done_o)
		else $error("clear never done");
	a_go_runs: assert property (counter_go_i |-> ##[1:40] counter_running_o)
		else $error("never running");
	a_run_holds: assert property (counter_running_o |=> counter_running_o)
		else $error("running dropped");
	a_rel_soon: assert property ($rose(arst_n_i) |-> ##[1:4] reset_released_flag_o)
		else $error("release flag late");
	a_rel_holds: assert property (reset_released_flag_o |=> reset_released_flag_o)
		else $error("release flag dropped");
	c_trig: cover property (adc_start_o);
	c_err: cover property ($rose(channel_error_flag_o[0]));
	c_irq: cover property (irq_o);
endmodule
bind tpwm_top tpwm_asserts #(.INST_ID(INST_ID), .TICK_DIV(TICK_DIV)) u_tpwm_asserts (
	.sys_clk_i, .arst_n_i, .counter_clear_request_i, .counter_go_i, .trigger_enable_i,
	.status_clear_i, .interrupt_mask_reg_i, .reset_released_flag_o, .counter_clear_done_o,
	.counter_running_o, .channel_status_o, .channel_error_flag_o, .overflow_status_o,
	.interrupt_status_o, .irq_o, .adc_start_o, .dac_start_o);

/* File: testbench/tpwm_conv_model.sv */
// Converter start input model: counts starts, flags a start mid-conversion.
// Assumes start pulses one clock wide on the block clock.
`timescale 1ns/1ps
module tpwm_conv_model #(
	parameter int CONV_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic start_i,
	output int starts_o,
	output int overruns_o
);
	int busy = 0;
	int starts = 0;
	int overruns = 0;
	// Counters drive the ports from one place only
	assign starts_o = starts;
	assign overruns_o = overruns;
	// Conversion timer; a start while busy means too short a period
	always @(posedge clk_i) begin
		if (start_i) begin
			starts <= starts + 1;
			if (busy > 0) overruns <= overruns + 1;
			busy <= CONV_CYCLES;
		end else if (busy > 0) busy <= busy - 1;
	end
endmodule

/* File: testbench/tpwm_tb.sv */
// Self-checking bench for the timer PWM block with converter models.
// Assumes default tick divide of one and instance number zero.
`timescale 1ns/1ps
module testbench;
	import tpwm_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic clr = 0;
	logic go = 0;
	logic ten = 0;
	logic [CNT_W-1:0] top = 16'h0009;
	logic [1:0] snap = 2'h1;
	logic [NCH-1:0][2:0] fs = '0;
	logic [NCH-1:0] output_polarity = '0;
	logic [NCH-1:0] rs = '0;
	logic [NCH-1:0] upd = '0;
	logic [NCH-1:0][MATCH_W-1:0] m0 = '0;
	logic [NCH-1:0][MATCH_W-1:0] m1 = '0;
	logic [SEL_W-1:0] tsel = '0;
	logic [DLY_W-1:0] dly = '0;
	logic [STS_W-1:0] sclr = '0;
	logic [STS_W-1:0] mask = '1;
	logic rel, done, run, ovf, irq, adc, dac, lv;
	logic [CNT_W-1:0] snapv;
	logic [NCH-1:0] pwm, sts, err;
	logic [STS_W-1:0] ints;
	int bad_count = 0;
	int checks = 0;
	int n, k, d0;
	int na, nd, ov;
	tpwm_top u_tpwm_top (.sys_clk_i(clk), .arst_n_i(rst_n), .counter_clear_request_i(clr),
		.counter_go_i(go), .counter_top_value_i(top), .snapshot_update_mode_i(snap),
		.channel_function_select_i(fs), .output_polarity_i(output_polarity), .match_value_first_i(m0),
		.match_value_second_i(m1), .channel_restart_i(rs), .match_update_request_i(upd),
		.trigger_source_channel_i(tsel), .trigger_enable_i(ten), .trigger_delay_i(dly),
		.status_clear_i(sclr), .interrupt_mask_reg_i(mask), .reset_released_flag_o(rel),
		.counter_clear_done_o(done), .counter_running_o(run), .counter_snapshot_o(snapv),
		.pwm_o(pwm), .channel_status_o(sts), .channel_error_flag_o(err),
		.overflow_status_o(ovf), .interrupt_status_o(ints), .irq_o(irq),
		.adc_start_o(adc), .dac_start_o(dac));
	tpwm_conv_model u_adc_model (.clk_i(clk), .start_i(adc), .starts_o(na), .overruns_o(ov));
	tpwm_conv_model u_dac_model (.clk_i(clk), .start_i(dac), .starts_o(nd), .overruns_o());
	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	function automatic logic pick(input int id);
		case (id)
			0: return rel;
			1: return done;
			2: return run;
			3: return sts[0];
			default: return adc;
		endcase
	endfunction
	// Bounded wait for a flag; n holds the cycles waited
	task automatic wait_bit(input int id, input int lim);
		n = 0;
		while (pick(id) !== 1'b1) begin
			cyc(1);
			n++;
			if (n > lim) begin
				chk(0, 1, "wait timeout");
				finish_test();
			end
		end
	endtask
	task automatic sc(input logic [STS_W-1:0] v);
		sclr = v;
		cyc(1);
		sclr = '0;
	endtask
	task automatic up;
		upd[0] = 1;
		cyc(1);
		upd[0] = 0;
	endtask
	// Highest snapshot seen over 30 cycles
	task automatic t_count(input logic [15:0] exp);
		k = 0;
		repeat (30) begin
			if (snapv > k) k = snapv;
			cyc(1);
		end
		chk(k, exp, "counter top");
	endtask
	task automatic t_init;
		cyc(8);
		rst_n = 1;
		wait_bit(0, 6);
		clr = 1;
		cyc(1);
		clr = 0;
		chk(done, 0, "clear pending");
		wait_bit(1, 10);
		go = 1;
		cyc(1);
		go = 0;
		wait_bit(2, 10);
		t_count(9);
		chk(ovf, 1, "overflow");
		top = 4;
		clr = 1;
		cyc(1);
		clr = 0;
		wait_bit(1, 10);
		t_count(4);
		snap = 2'h0;
	endtask
	// Restart channel 0 and count active cycles over four periods
	task automatic t_pwm(input logic [2:0] f, input logic p, input logic [15:0] a, b, act, per);
		fs[0] = f;
		output_polarity[0] = p;
		m0[0] = a;
		m1[0] = b;
		rs[0] = 1;
		cyc(1);
		rs[0] = 0;
		cyc(3 * per + 10);
		// Clear status so every call proves its own period end
		sc(13'h0001);
		k = 0;
		repeat (4 * per) begin
			k += (pwm[0] !== p);
			cyc(1);
		end
		chk(k, 4 * act, "active cycles");
		chk(sts[0], 1, "period status");
	endtask
	task automatic t_pause;
		m0[0] = 0;
		m1[0] = 0;
		up();
		cyc(20);
		sc(13'h0001);
		lv = pwm[0];
		cyc(30);
		chk(sts[0], 0, "paused status");
		chk(pwm[0], lv, "paused level");
		m0[0] = 2;
		m1[0] = 3;
		up();
		cyc(20);
		chk(sts[0], 1, "restarted");
	endtask
	task automatic t_err;
		m0[0] = 20;
		m1[0] = 20;
		up();
		cyc(10);
		up();
		cyc(6);
		up();
		cyc(2);
		chk(err[0], 1, "overlap error");
		chk(irq, 0, "masked irq");
		mask[6] = 0;
		cyc(1);
		chk(ints[6], 1, "unmasked bit");
		chk(irq, 1, "irq");
		mask = '1;
		sc(13'h0040);
		chk(err[0], 0, "error cleared");
	endtask
	task automatic t_trig;
		ten = 1;
		sc(13'h0001);
		wait_bit(3, 50);
		wait_bit(4, 50);
		d0 = n;
		dly = 2;
		sc(13'h0001);
		wait_bit(3, 50);
		wait_bit(4, 50);
		chk(n - d0, 8, "trigger delay");
		k = na;
		cyc(120);
		chk(na - k, 3, "trigger count");
		ten = 0;
		// Let a pulse fired while still enabled reach the model
		cyc(2);
		k = na;
		cyc(120);
		chk(na - k, 0, "disabled trigger");
		ten = 1;
		tsel = 1;
		k = na;
		cyc(120);
		chk(na - k, 0, "idle source");
	endtask
	initial begin
		t_init();
		t_pwm(FUNC_PWM_CENTER, 1, 2, 3, 4, 10);
		t_pwm(FUNC_PWM_EDGE, 0, 0, 3, 0, 3);
		t_pwm(FUNC_PWM_EDGE, 1, 3, 0, 3, 3);
		t_pwm(FUNC_PWM_CENTER, 0, 0, 3, 0, 6);
		t_pwm(FUNC_PWM_CENTER, 0, 3, 0, 6, 6);
		t_pwm(FUNC_PWM_EDGE, 0, 2, 3, 2, 5);
		t_pause();
		t_err();
		t_trig();
		chk(nd, 0, "dac start");
		chk(ov, 0, "conversion overrun");
		finish_test();
	end
endmodule
